// ===== amplitude_decode.sv
// Oscillator output amplitude code to millivolts
module amplitude_decode (
	input  wire logic [1:0]  osc_out_amplitude,
	input  wire logic        osc_out_format,
	output logic [9:0]       amplitude_mv
);
	// Format is deliberately unused: the swing is the same for both
	logic unused_format;
	assign unused_format = osc_out_format;

	always_comb begin
		unique case (osc_out_amplitude)
			2'h0: amplitude_mv = 10'h0FA;
			2'h1: amplitude_mv = 10'h1F4;
			2'h2: amplitude_mv = 10'h1F4;
			2'h3: amplitude_mv = 10'h2EE;
		endcase
	end
endmodule

// ===== rank_picker.sv
// Combinational pick of the best valid input by rank code and index
module rank_picker #(
	parameter int N = 4
) (
	input  wire logic [2*N-1:0]         input_rank,
	input  wire logic [N-1:0]           valid,
	output logic                        found,
	output logic [$clog2(N)-1:0]        best
);
	if (N < 2) begin : g_bad_n
		$error("rank_picker needs at least two inputs");
	end

	always_comb begin
		found = 1'b0;
		best  = '0;
		// Highest index first so lower index wins ties with >=
		for (int i = N - 1; i >= 0; i--) begin
			if (valid[i] && (!found || input_rank[2*i +: 2] >= input_rank[2*best +: 2])) begin
				found = 1'b1;
				best  = ($clog2(N))'(i);
			end
		end
	end
endmodule

// ===== ref_input_priority_select.sv
// Reference input priority selector with its configuration registers
// How it works
// - each input has a two bit rank, 00 lowest through 11 highest.
// - equal ranks are ordered by index, input 0 first.
// - ranks reset to 11, 10, 01, 00 for inputs 0 to 3.
// - revertive enable only matters when the mode low bit is one.
// - revertive off: a returning unselected input leaves the choice alone.
// - revertive on: returning input causes switch only if it outranks current one.
// - revertive enable resets to zero.
// - monitor pre-divider bit: 0 divides by one, 1 divides by four.
// - phase offset enable applies the static offset; resets to zero.
// - five bit static offset, code times f_PFD over 400, resets to zero.
// - five bit pump current, 400 uA times code plus one, resets to 24.
// - mode 00 manual, 01 auto, 10 short holdover, 11 auto with holdover.
// - manual modes use the select field; automatic modes ignore it.
//
// The strobed register port was decided locally.
module ref_input_priority_select #(
	parameter int N = 4
) (
	input  wire logic                   clk,
	input  wire logic                   reset,
	input  wire logic [7:0]             addr,
	input  wire logic [7:0]             wdata,
	input  wire logic                   wr,
	input  wire logic                   rd,
	output logic [7:0]                  rdata,
	input  wire logic [N-1:0]           input_lost,
	input  wire logic                   osc_out_format,
	output logic [1:0]                  selected_input,
	output logic                        selected_valid,
	output logic                        auto_mode,
	output logic [2:0]                  monitor_prediv,
	output logic [9:0]                  osc_amplitude_mv,
	output ref_select_pkg::static_cfg_t cfg
);
	if (N != 4) begin : g_bad_n
		$error("register layout serves exactly four inputs");
	end

	typedef struct packed {
		logic [7:0]                  input_priority;
		logic [7:0]                  selection_mode_control;
		logic [7:0]                  holdoff_count;
		logic [7:0]                  counter_range_power;
		logic                        phase_offset_enable;
		logic [4:0]                  phase_offset;
		logic [4:0]                  stage2_pump_current;
		logic [1:0]                  osc_out_amplitude;
		logic [1:0]                  current;
		logic                        have_current;
		logic [N-1:0]                lost_seen;
		ref_select_pkg::sel_state_t  state;
		logic [7:0]                  rdata;
	} state_t;

	state_t s;
	state_t next_s;

	ref_select_pkg::reg_req_t req;
	logic [1:0]  selection_mode;
	logic [1:0]  manual_sel;
	logic        revertive_enable;
	logic        is_auto;
	logic [N-1:0] valid;
	logic [N-1:0] revalidated;
	logic        best_found;
	logic [1:0]  best;
	logic        revert_active;
	logic [2*N-1:0] rank_vec;
	logic        revert_due;

	assign req.addr  = addr;
	assign req.wdata = wdata;
	assign req.wr    = wr;
	assign req.rd    = rd;

	assign manual_sel       = s.selection_mode_control[ref_select_pkg::SEL_LSB +: 2];
	assign selection_mode   = s.selection_mode_control[ref_select_pkg::MODE_LSB +: 2];
	assign revertive_enable = s.selection_mode_control[ref_select_pkg::REVERT_BIT];
	assign is_auto          = selection_mode[0];
	assign valid            = ~input_lost;
	assign revalidated      = s.lost_seen & valid;
	assign revert_active    = is_auto && revertive_enable;

	rank_picker #(
		.N          (N)
	) u_pick (
		.input_rank (rank_vec),
		.valid      (valid),
		.found      (best_found),
		.best       (best)
	);

	amplitude_decode u_ampl (
		.osc_out_amplitude (s.osc_out_amplitude),
		.osc_out_format    (osc_out_format),
		.amplitude_mv      (osc_amplitude_mv)
	);

	// Rank code of input i held in the priority register, input 0 in the top bits
	function automatic logic [1:0] rank_of(input logic [7:0] pr, input logic [1:0] i);
		rank_of = pr[2*(3-i) +: 2];
	endfunction

	// Remap register layout (input 0 high) to picker layout (input 0 low)
	always_comb begin
		for (int i = 0; i < N; i++) begin
			rank_vec[2*i +: 2] = rank_of(s.input_priority, 2'(i));
		end
	end

	// True when input a outranks input b, the lower index winning a tie
	function automatic logic outranks(input logic [2*N-1:0] rv, input logic [1:0] a,
		input logic [1:0] b);
		outranks = (rv[2*a +: 2] > rv[2*b +: 2])
			|| (rv[2*a +: 2] == rv[2*b +: 2] && a < b);
	endfunction

	// Only a returning input that outranks the current one may cause a switch
	always_comb begin
		revert_due = 1'b0;
		for (int i = 0; i < N; i++) begin
			if (revalidated[i] && outranks(rank_vec, 2'(i), s.current)) begin
				revert_due = 1'b1;
			end
		end
	end

	always_comb begin
		next_s       = s;
		next_s.rdata = 8'h00;

		// Register writes
		if (req.wr) begin
			unique case (req.addr)
				ref_select_pkg::INPUT_PRIORITY_ADDR:
					next_s.input_priority = req.wdata;
				ref_select_pkg::SELECTION_MODE_CONTROL_ADDR:
					next_s.selection_mode_control = {1'b0, req.wdata[6:0]};
				ref_select_pkg::HOLDOFF_COUNT_ADDR:
					next_s.holdoff_count = req.wdata;
				ref_select_pkg::COUNTER_RANGE_POWER_ADDR:
					next_s.counter_range_power = req.wdata;
				ref_select_pkg::PLL_PHASE_ADDR: begin
					next_s.phase_offset        = req.wdata[ref_select_pkg::OFFSET_LSB +: 5];
					next_s.phase_offset_enable = req.wdata[ref_select_pkg::OFFSET_EN_BIT];
				end
				ref_select_pkg::PLL_ANALOG_ADDR: begin
					next_s.stage2_pump_current = req.wdata[ref_select_pkg::PUMP_LSB +: 5];
					next_s.osc_out_amplitude   = req.wdata[ref_select_pkg::AMPL_LSB +: 2];
				end
				default: ;
			endcase
		end

		// Register reads, data stands one cycle later
		if (req.rd) begin
			unique case (req.addr)
				ref_select_pkg::INPUT_PRIORITY_ADDR:         next_s.rdata = s.input_priority;
				ref_select_pkg::SELECTION_MODE_CONTROL_ADDR: next_s.rdata = s.selection_mode_control;
				ref_select_pkg::HOLDOFF_COUNT_ADDR:          next_s.rdata = s.holdoff_count;
				ref_select_pkg::COUNTER_RANGE_POWER_ADDR:    next_s.rdata = s.counter_range_power;
				ref_select_pkg::PLL_PHASE_ADDR:
					next_s.rdata = {2'h0, s.phase_offset_enable, s.phase_offset};
				ref_select_pkg::PLL_ANALOG_ADDR:
					next_s.rdata = {1'b0, s.osc_out_amplitude, s.stage2_pump_current};
				ref_select_pkg::SELECT_STATUS_ADDR:
					next_s.rdata = {s.have_current, 1'b0, valid, s.current};
				default: next_s.rdata = 8'h00;
			endcase
		end

		// Remember which inputs have been lost, to spot re-validation
		next_s.lost_seen = (s.lost_seen & ~valid) | input_lost;

		// Reference selection
		if (!is_auto) begin
			next_s.current      = manual_sel;
			next_s.have_current = 1'b1;
			next_s.state        = ref_select_pkg::SEL_LOCKED;
		end else begin
			unique case (s.state)
				ref_select_pkg::SEL_IDLE: begin
					if (best_found) begin
						next_s.current      = best;
						next_s.have_current = 1'b1;
						next_s.state        = ref_select_pkg::SEL_LOCKED;
					end else begin
						next_s.have_current = 1'b0;
					end
				end
				ref_select_pkg::SEL_LOCKED: begin
					if (input_lost[s.current]) begin
						// Current reference failed: fail over to best remaining
						if (best_found) begin
							next_s.current = best;
						end else begin
							next_s.have_current = 1'b0;
							next_s.state        = ref_select_pkg::SEL_IDLE;
						end
					end else if (revert_active && revert_due && best_found
						&& best != s.current) begin
						next_s.current = best;
					end
					// Without revertive switching a returning input is ignored
				end
				default: next_s.state = ref_select_pkg::SEL_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			s.input_priority         <= ref_select_pkg::INPUT_PRIORITY_RST;
			s.selection_mode_control <= ref_select_pkg::SELECTION_MODE_CONTROL_RST;
			s.holdoff_count          <= ref_select_pkg::HOLDOFF_COUNT_RST;
			s.counter_range_power    <= ref_select_pkg::COUNTER_RANGE_POWER_RST;
			s.phase_offset_enable    <= 1'b0;
			s.phase_offset           <= ref_select_pkg::OFFSET_RST;
			s.stage2_pump_current    <= ref_select_pkg::PUMP_RST;
			s.osc_out_amplitude      <= ref_select_pkg::AMPL_RST;
			s.current                <= 2'h0;
			s.have_current           <= 1'b0;
			s.lost_seen              <= '0;
			s.state                  <= ref_select_pkg::SEL_IDLE;
			s.rdata                  <= 8'h00;
		end else begin
			s <= next_s;
		end
	end

	assign rdata          = s.rdata;
	assign selected_input = s.current;
	assign selected_valid = s.have_current;
	assign auto_mode      = is_auto;
	// Divide ratio presented to the activity counter
	assign monitor_prediv = s.selection_mode_control[ref_select_pkg::PREDIV_BIT] ? 3'h4 : 3'h1;

	always_comb begin
		cfg.offset_enable       = s.phase_offset_enable;
		cfg.phase_offset        = s.phase_offset_enable ? s.phase_offset : 5'h00;
		cfg.stage2_pump_current = s.stage2_pump_current;
		cfg.osc_out_amplitude   = s.osc_out_amplitude;
		cfg.monitor_prediv_sel  = s.selection_mode_control[ref_select_pkg::PREDIV_BIT];
		cfg.lock_loss_block     = s.selection_mode_control[ref_select_pkg::LOCKBLOCK_BIT];
		cfg.holdoff_period      = s.holdoff_count;
		cfg.holdoff_prescale    = s.counter_range_power[7:6];
		cfg.input_powerdown     = s.counter_range_power[5:2];
		cfg.activity_count_cfg  = s.counter_range_power[1:0];
	end
endmodule

// ===== ref_input_priority_select_tb.sv
// Self-checking bench of the reference selector
module ref_input_priority_select_tb;
	timeunit 1ns;
	timeprecision 100ps;
	typedef struct packed {
		logic [7:0] ctl;
		logic [7:0] prio;
		logic [3:0] lost;
		logic [1:0] sel;
		logic       ok;
	} row_t;
	logic                        clk = 1'b0;
	logic                        reset = 1'b1;
	logic [3:0]                  input_lost = 4'hF;
	logic                        osc_out_format = 1'b0;
	logic [7:0]                  addr, wdata, rdata, d;
	logic                        wr, rd, selected_valid, auto_mode;
	logic [1:0]                  selected_input;
	logic [2:0]                  monitor_prediv;
	logic [9:0]                  osc_amplitude_mv;
	ref_select_pkg::static_cfg_t cfg;
	int                          num_errors = 0;
	int                          compares = 0;
	int                          cycles = 0;
	logic [7:0]                  rst_val [6] = '{8'hE4, 8'h00, 8'h80, 8'h80, 8'h00, 8'h18};
	row_t                        rows [8] = '{
		'{8'h02, 8'hE4, 4'h0, 2'h2, 1'b1},
		'{8'h1B, 8'hE4, 4'h0, 2'h3, 1'b1},
		'{8'h17, 8'hE4, 4'h0, 2'h0, 1'b1},
		'{8'h1C, 8'hE4, 4'h1, 2'h1, 1'b1},
		'{8'h14, 8'h1B, 4'h0, 2'h3, 1'b1},
		'{8'h14, 8'h00, 4'h3, 2'h2, 1'b1},
		'{8'h34, 8'h55, 4'hE, 2'h0, 1'b1},
		'{8'h14, 8'hE4, 4'hF, 2'h0, 1'b0}};
	sw_master i_sw (.clk(clk), .rdata(rdata), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd));
	ref_input_priority_select #(.N(4)) i_dut (.clk(clk), .reset(reset), .addr(addr),
		.wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .input_lost(input_lost),
		.osc_out_format(osc_out_format), .selected_input(selected_input),
		.selected_valid(selected_valid), .auto_mode(auto_mode),
		.monitor_prediv(monitor_prediv), .osc_amplitude_mv(osc_amplitude_mv), .cfg(cfg));
	initial forever #5 clk = ~clk;
	task wrap_up;
		$display("compares %0d num_errors %0d", compares, num_errors);
		if (num_errors == 0 && compares > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	always @(posedge clk) begin
		cycles++;
		if (cycles == 3000) begin
			num_errors++;
			wrap_up();
		end
	end
	task chk_val(input logic [9:0] got, input logic [9:0] exp);
		compares++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task chk_sel(input logic [1:0] s, input logic v);
		compares++;
		if (selected_valid !== v || (v && selected_input !== s)) begin
			num_errors++;
			$display("unexpected at %0t: got %h/%h expected %h/%h", $time,
				selected_input, selected_valid, s, v);
		end
	endtask
	task step(input logic [3:0] l, input logic [1:0] s, input logic v);
		@(posedge clk);
		input_lost <= l;
		repeat (3) @(posedge clk);
		#1;
		chk_sel(s, v);
	endtask
	initial begin
		repeat (6) @(posedge clk);
		reset <= 1'b0;
		foreach (rows[i]) begin
			@(posedge clk);
			input_lost <= 4'hF;
			i_sw.write_reg(8'h14, rows[i].prio);
			i_sw.write_reg(8'h15, rows[i].ctl);
			step(rows[i].lost, rows[i].sel, rows[i].ok);
			chk_val(10'(auto_mode), 10'(rows[i].ctl[2]));
		end
		$display("test table done");
		i_sw.write_reg(8'h15, 8'h14);
		step(4'h0, 2'h0, 1'b1);
		step(4'h1, 2'h1, 1'b1);
		step(4'h0, 2'h0, 1'b1);
		step(4'h2, 2'h0, 1'b1);
		step(4'h0, 2'h0, 1'b1);
		i_sw.write_reg(8'h15, 8'h04);
		step(4'h1, 2'h1, 1'b1);
		step(4'h0, 2'h1, 1'b1);
		i_sw.read_reg(8'h1A, d);
		chk_val(10'(d), 10'h0BD);
		i_sw.write_reg(8'h15, 8'h14);
		step(4'h8, 2'h1, 1'b1);
		step(4'h0, 2'h1, 1'b1);
		step(4'h1, 2'h1, 1'b1);
		step(4'h0, 2'h0, 1'b1);
		i_sw.read_reg(8'h1A, d);
		chk_val(10'(d), 10'h0BC);
		$display("test revertive done");
		i_sw.write_reg(8'h18, 8'h1F);
		i_sw.read_reg(8'h18, d);
		chk_val(10'(d), 10'h01F);
		chk_val(10'(cfg.phase_offset), 10'h000);
		i_sw.write_reg(8'h18, 8'h3F);
		i_sw.write_reg(8'h19, 8'h7F);
		@(posedge clk);
		osc_out_format <= 1'b1;
		@(posedge clk);
		#1;
		chk_val(10'(cfg.phase_offset), 10'h01F);
		chk_val(10'(cfg.offset_enable), 10'h001);
		chk_val(10'(cfg.stage2_pump_current), 10'h01F);
		chk_val(osc_amplitude_mv, 10'h2EE);
		chk_val(10'(monitor_prediv), 10'h001);
		i_sw.read_reg(8'h19, d);
		chk_val(10'(d), 10'h07F);
		i_sw.write_reg(8'h15, 8'hFF);
		i_sw.read_reg(8'h15, d);
		chk_val(10'(d), 10'h07F);
		chk_val(10'(monitor_prediv), 10'h004);
		chk_val(10'(cfg.monitor_prediv_sel), 10'h001);
		i_sw.write_reg(8'h1B, 8'h55);
		i_sw.read_reg(8'h1B, d);
		chk_val(10'(d), 10'h000);
		$display("test static done");
		@(posedge clk);
		reset <= 1'b1;
		repeat (2) @(posedge clk);
		reset <= 1'b0;
		foreach (rst_val[i]) begin
			i_sw.read_reg(8'h14 + 8'(i), d);
			chk_val(10'(d), 10'(rst_val[i]));
		end
		chk_val(10'(cfg.stage2_pump_current), 10'h018);
		step(4'hF, 2'h0, 1'b1);
		$display("test reset done");
		wrap_up();
	end
endmodule

// ===== ref_select_asserts.sv
// Port checks of the reference selector
module ref_select_asserts #(
	parameter int N = 4
) (
	input wire logic                        clk,
	input wire logic                        reset,
	input wire logic [7:0]                  addr,
	input wire logic [7:0]                  wdata,
	input wire logic                        wr,
	input wire logic                        rd,
	input wire logic [7:0]                  rdata,
	input wire logic [N-1:0]                input_lost,
	input wire logic                        osc_out_format,
	input wire logic [1:0]                  selected_input,
	input wire logic                        selected_valid,
	input wire logic                        auto_mode,
	input wire logic [2:0]                  monitor_prediv,
	input wire logic [9:0]                  osc_amplitude_mv,
	input wire ref_select_pkg::static_cfg_t cfg
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);
	sequence s_manual2;
		!reset && !auto_mode ##1 !auto_mode;
	endsequence
	sequence s_all_lost;
		auto_mode && input_lost == {N{1'b1}};
	endsequence
	sequence s_cur_lost;
		auto_mode && selected_valid && input_lost[selected_input] && input_lost != {N{1'b1}};
	endsequence
	sequence s_quiet;
		auto_mode && !wr ##1 auto_mode && !wr && $stable(input_lost);
	endsequence
	prediv_value_a: assert property (
		monitor_prediv == (cfg.monitor_prediv_sel ? 3'h4 : 3'h1))
		else $error("pre-divider value wrong");
	ampl_decode_a: assert property (
		osc_amplitude_mv == (cfg.osc_out_amplitude == 2'h0 ? 10'h0FA :
		(cfg.osc_out_amplitude == 2'h3 ? 10'h2EE : 10'h1F4)))
		else $error("amplitude decode wrong");
	format_free_a: assert property (
		$changed(osc_out_format) && $stable(cfg.osc_out_amplitude) |-> $stable(osc_amplitude_mv))
		else $error("amplitude follows format");
	offset_gate_a: assert property (
		!cfg.offset_enable |-> cfg.phase_offset == 5'h00)
		else $error("offset applied while disabled");
	manual_valid_a: assert property (s_manual2 |-> selected_valid)
		else $error("manual mode without reference");
	failover_pick_a: assert property (
		s_cur_lost ##1 (auto_mode && $stable(input_lost)) |-> !input_lost[selected_input])
		else $error("lost input kept selected");
	all_lost_a: assert property (s_all_lost ##1 s_all_lost |-> !selected_valid)
		else $error("reference chosen with all inputs lost");
	quiet_hold_a: assert property (s_quiet |=> $stable(selected_input))
		else $error("selection moved without cause");
endmodule

bind ref_input_priority_select ref_select_asserts #(.N(N)) i_chk (
	.clk(clk), .reset(reset), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
	.rdata(rdata), .input_lost(input_lost), .osc_out_format(osc_out_format),
	.selected_input(selected_input), .selected_valid(selected_valid),
	.auto_mode(auto_mode), .monitor_prediv(monitor_prediv),
	.osc_amplitude_mv(osc_amplitude_mv), .cfg(cfg));

// ===== ref_select_pkg.sv
// Register map, field layout, reset values and state types of the reference selector
package ref_select_pkg;

	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;

	// Register offsets
	localparam logic [7:0] INPUT_PRIORITY_ADDR         = 8'h14;
	localparam logic [7:0] SELECTION_MODE_CONTROL_ADDR = 8'h15;
	localparam logic [7:0] HOLDOFF_COUNT_ADDR          = 8'h16;
	localparam logic [7:0] COUNTER_RANGE_POWER_ADDR    = 8'h17;
	localparam logic [7:0] PLL_PHASE_ADDR              = 8'h18;
	localparam logic [7:0] PLL_ANALOG_ADDR             = 8'h19;
	localparam logic [7:0] SELECT_STATUS_ADDR          = 8'h1A;

	// Field positions in selection_mode_control
	localparam int SEL_LSB       = 0;
	localparam int MODE_LSB      = 2;
	localparam int REVERT_BIT    = 4;
	localparam int PREDIV_BIT    = 5;
	localparam int LOCKBLOCK_BIT = 6;

	// Field positions in pll_phase and pll_analog
	localparam int OFFSET_LSB     = 0;
	localparam int OFFSET_EN_BIT  = 5;
	localparam int PUMP_LSB       = 0;
	localparam int AMPL_LSB       = 5;

	// Reset values
	localparam logic [7:0] INPUT_PRIORITY_RST         = 8'hE4;
	localparam logic [7:0] SELECTION_MODE_CONTROL_RST = 8'h00;
	localparam logic [7:0] HOLDOFF_COUNT_RST          = 8'h80;
	localparam logic [7:0] COUNTER_RANGE_POWER_RST    = 8'h80;
	localparam logic [4:0] OFFSET_RST                 = 5'h00;
	localparam logic [4:0] PUMP_RST                   = 5'h18;
	localparam logic [1:0] AMPL_RST                   = 2'h0;

	// Selection modes
	localparam logic [1:0] MODE_MANUAL      = 2'h0;
	localparam logic [1:0] MODE_AUTO        = 2'h1;
	localparam logic [1:0] MODE_SHORT_HOLD  = 2'h2;
	localparam logic [1:0] MODE_AUTO_HOLD   = 2'h3;

	typedef enum logic [1:0] {
		SEL_IDLE,
		SEL_LOCKED
	} sel_state_t;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} reg_req_t;

	typedef struct packed {
		logic       offset_enable;
		logic [4:0] phase_offset;
		logic [4:0] stage2_pump_current;
		logic [1:0] osc_out_amplitude;
		logic       monitor_prediv_sel;
		logic       lock_loss_block;
		logic [7:0] holdoff_period;
		logic [1:0] holdoff_prescale;
		logic [3:0] input_powerdown;
		logic [1:0] activity_count_cfg;
	} static_cfg_t;

endpackage

// ===== sw_master.sv
// Software side register master on the plain port
module sw_master (
	input  wire logic       clk,
	input  wire logic [7:0] rdata,
	output logic [7:0]      addr,
	output logic [7:0]      wdata,
	output logic            wr,
	output logic            rd
);
	timeunit 1ns;
	timeprecision 100ps;
	initial begin
		addr = 8'h00;
		wdata = 8'h00;
		wr = 1'b0;
		rd = 1'b0;
	end
	task automatic write_reg(input logic [7:0] a, input logic [7:0] v);
		@(posedge clk);
		addr <= a;
		wdata <= v;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	// Read data stand only in the cycle after the strobe
	task automatic read_reg(input logic [7:0] a, output logic [7:0] v);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		v = rdata;
	endtask
endmodule
